/* logic/cprr_pkg.sv */
// package: constants for the codec power and readback register slice
// assumes: 16-bit serial control words, 7-bit address then 9-bit data

package cprr_pkg;

  // ************************************************************
  // serial frame layout
  // ************************************************************
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned DATA_W        = 9;
  localparam logic [4:0]  FRAME_BITS_C  = 5'h10;
  localparam logic [4:0]  BIT_CNT_MAX   = 5'h1f;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [6:0] OFS_POWER_DOWN_ONE   = 7'h32;
  localparam logic [6:0] OFS_POWER_DOWN_TWO   = 7'h33;
  localparam logic [6:0] OFS_READBACK_CONTROL = 7'h34;
  localparam logic [6:0] OFS_SOFTWARE_RESET   = 7'h35;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [8:0] RST_POWER_DOWN_ONE   = 9'h07e;
  localparam logic [8:0] RST_POWER_DOWN_TWO   = 9'h03e;
  localparam logic [8:0] RST_READBACK_CONTROL = 9'h000;

  // ************************************************************
  // power_down_one fields
  // ************************************************************
  localparam int unsigned BIT_CHIP_POWER_SAVE = 0;
  localparam int unsigned BIT_ADC_POWER_OFF   = 1;
  localparam int unsigned BIT_DAC_LO          = 2;
  localparam int unsigned BIT_DAC_HI          = 5;
  localparam int unsigned BIT_ALL_DACS_OFF    = 6;

  // ************************************************************
  // power_down_two fields
  // ************************************************************
  localparam int unsigned BIT_OSCILLATOR_OFF     = 0;
  localparam int unsigned BIT_FIRST_PLL_OFF      = 1;
  localparam int unsigned BIT_SECOND_PLL_OFF     = 2;
  localparam int unsigned BIT_CLOCK_RECOVERY_OFF = 3;
  localparam int unsigned BIT_TRANSMITTER_OFF    = 4;
  localparam int unsigned BIT_RECEIVER_OFF       = 5;

  // ************************************************************
  // readback_control fields and selector codes
  // ************************************************************
  localparam int unsigned BIT_SEL_LO              = 0;
  localparam int unsigned BIT_SEL_HI              = 2;
  localparam int unsigned BIT_CONTINUOUS_READBACK = 3;
  localparam int unsigned BIT_READBACK_ENABLE     = 4;
  localparam logic [2:0]  SEL_ERROR               = 3'h0;
  localparam logic [2:0]  SEL_CHAN_FIRST          = 3'h1;
  localparam logic [2:0]  SEL_CHAN_LAST           = 3'h5;
  localparam logic [2:0]  SEL_RX_STATUS           = 3'h6;

  // ************************************************************
  // receiver status layout
  // ************************************************************
  localparam int unsigned BIT_BAND_LO = 4;
  localparam int unsigned BIT_BAND_HI = 5;
  localparam int unsigned BIT_UNLOCK  = 6;
  localparam logic [1:0]  BAND_INVALID = 2'h0;
  localparam logic [1:0]  BAND_96K     = 2'h1;
  localparam logic [1:0]  BAND_48K     = 2'h2;
  localparam logic [1:0]  BAND_32K     = 2'h3;

endpackage

/* logic/cprr_serial.sv */
// serial control port receiver: synchronises pins, assembles write words
// assumes: serial clock well below a quarter of mclk, latch low frames a word
`timescale 1ns/10ps

module cprr_serial
  import cprr_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  // serial pins
  input  wire logic              sclk_i,
  input  wire logic              sdin_i,
  input  wire logic              latch_n_i,
  // decoded write
  output logic                   wr_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [DATA_W-1:0]      wr_data_o,
  // frame timing
  output logic                   frame_start_o,
  output logic                   sclk_fall_o,
  output logic                   frame_active_o
);

  // ************************************************************
  // pin synchronisers and shift state
  // ************************************************************
  logic [2:0]            sclk_s_r;
  logic [2:0]            latch_s_r;
  logic [1:0]            sdin_s_r;
  logic [FRAME_BITS-1:0] shift_r,  shift_nxt;
  logic [4:0]            cnt_r,    cnt_nxt;
  logic                  wr_r,     wr_nxt;
  logic                  sclk_rise;
  logic                  latch_rise;
  logic                  latch_fall;

  assign sclk_rise      = sclk_s_r[1] & ~sclk_s_r[2];
  assign sclk_fall_o    = ~sclk_s_r[1] & sclk_s_r[2];
  assign latch_rise     = latch_s_r[1] & ~latch_s_r[2];
  assign latch_fall     = ~latch_s_r[1] & latch_s_r[2];
  assign frame_start_o  = latch_fall;
  assign frame_active_o = ~latch_s_r[2];
  assign wr_o           = wr_r;
  assign wr_addr_o      = shift_r[FRAME_BITS-1:DATA_W];
  assign wr_data_o      = shift_r[DATA_W-1:0];

  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    wr_nxt    = 1'b0;
    if (latch_fall) begin
      cnt_nxt = 5'h00;
    end else if (sclk_rise && !latch_s_r[1]) begin
      shift_nxt = {shift_r[FRAME_BITS-2:0], sdin_s_r[1]};
      if (cnt_r != BIT_CNT_MAX) begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    if (latch_rise && cnt_r == FRAME_BITS_C) begin
      wr_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_s_r  <= 3'h0;
      latch_s_r <= 3'h7;
      sdin_s_r  <= 2'h0;
      shift_r   <= '0;
      cnt_r     <= 5'h00;
      wr_r      <= 1'b0;
    end else begin
      sclk_s_r  <= {sclk_s_r[1:0], sclk_i};
      latch_s_r <= {latch_s_r[1:0], latch_n_i};
      sdin_s_r  <= {sdin_s_r[0], sdin_i};
      shift_r   <= shift_nxt;
      cnt_r     <= cnt_nxt;
      wr_r      <= wr_nxt;
    end
  end

endmodule

/* logic/cprr_top.sv */
// register slice: power-down controls, readback selector, software reset
// assumes: status inputs come from logic on mclk except the receiver lock
// and band, which arrive from the clock recovery domain and are synchronised
//
// How it works
// [R1] receiver band reported at status bits 5:4
// [R2] status bit 6 high when receiver unlocked
// [R3] bit 0 puts chip in power save, muted
// [R4] adc and per-dac off bits, reset high
// [R5] bit 6 forces all four dacs off
// [R6] oscillator and two plls off bits
// [R7] bit 3 powers down clock recovery
// [R8] bit 4 disables the transmitter
// [R9] bit 5 disables the receiver
// [R10] three-bit selector picks readback status register
// [R11] bit 3 selects continuous readback
// [R12] bit 4 enables readback
// [R13] any write to 35h restores defaults
`timescale 1ns/10ps

module cprr_top
  import cprr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // serial control pins
  input  wire logic        sclk_i,
  input  wire logic        sdin_i,
  input  wire logic        latch_n_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  // receiver status sources
  input  wire logic [1:0]  rx_band_i,
  input  wire logic        rx_unlock_i,
  input  wire logic [3:0]  rx_flags_i,
  input  wire logic [7:0]  err_status_i,
  input  wire logic [39:0] chan_status_i,
  // power controls
  output logic             chip_power_save_o,
  output logic             mute_o,
  output logic             adc_power_off_o,
  output logic [3:0]       dac_power_off_o,
  output logic             oscillator_off_o,
  output logic             first_pll_off_o,
  output logic             second_pll_off_o,
  output logic             clock_recovery_off_o,
  output logic             transmitter_off_o,
  output logic             receiver_off_o
);

  // ************************************************************
  // serial port
  // ************************************************************
  logic              wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              frame_start;
  logic              sclk_fall;
  logic              frame_active;

  cprr_serial u_serial (
    .mclk_i         (mclk_i),
    .nrst_i         (nrst_i),
    .sclk_i         (sclk_i),
    .sdin_i         (sdin_i),
    .latch_n_i      (latch_n_i),
    .wr_o           (wr),
    .wr_addr_o      (wr_addr),
    .wr_data_o      (wr_data),
    .frame_start_o  (frame_start),
    .sclk_fall_o    (sclk_fall),
    .frame_active_o (frame_active)
  );

  // ************************************************************
  // control registers
  // ************************************************************
  logic [8:0] pd1_r,  pd1_nxt;
  logic [8:0] pd2_r,  pd2_nxt;
  logic [8:0] rb_r,   rb_nxt;
  logic       shot_r, shot_nxt;
  logic       soft_rst;
  logic       rb_go;

  assign soft_rst = wr && wr_addr == OFS_SOFTWARE_RESET;

  always_comb begin
    pd1_nxt  = pd1_r;
    pd2_nxt  = pd2_r;
    rb_nxt   = rb_r;
    shot_nxt = shot_r;
    if (rb_go) begin
      shot_nxt = 1'b0;
    end
    if (soft_rst) begin
      pd1_nxt  = RST_POWER_DOWN_ONE;                         // [R13]
      pd2_nxt  = RST_POWER_DOWN_TWO;                         // [R13]
      rb_nxt   = RST_READBACK_CONTROL;                       // [R13]
      shot_nxt = 1'b0;
    end else if (wr && wr_addr == OFS_POWER_DOWN_ONE) begin
      pd1_nxt = wr_data;
    end else if (wr && wr_addr == OFS_POWER_DOWN_TWO) begin
      pd2_nxt = wr_data;
    end else if (wr && wr_addr == OFS_READBACK_CONTROL) begin
      rb_nxt   = wr_data;
      shot_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd1_r  <= RST_POWER_DOWN_ONE;
      pd2_r  <= RST_POWER_DOWN_TWO;
      rb_r   <= RST_READBACK_CONTROL;
      shot_r <= 1'b0;
    end else begin
      pd1_r  <= pd1_nxt;
      pd2_r  <= pd2_nxt;
      rb_r   <= rb_nxt;
      shot_r <= shot_nxt;
    end
  end

  // ************************************************************
  // receiver status
  // ************************************************************
  logic [1:0] band_s1_r;
  logic [1:0] band_s2_r;
  logic       unlock_s1_r;
  logic       unlock_s2_r;
  logic [8:0] rx_status;
  logic       rx_unlock;
  logic [1:0] rx_band;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      band_s1_r   <= 2'h0;
      band_s2_r   <= 2'h0;
      unlock_s1_r <= 1'b1;
      unlock_s2_r <= 1'b1;
    end else begin
      band_s1_r   <= rx_band_i;
      band_s2_r   <= band_s1_r;
      unlock_s1_r <= rx_unlock_i;
      unlock_s2_r <= unlock_s1_r;
    end
  end

  always_comb begin
    rx_unlock = unlock_s2_r | pd2_r[BIT_CLOCK_RECOVERY_OFF]
              | pd2_r[BIT_RECEIVER_OFF];                     // [R2]
    rx_band   = rx_unlock ? BAND_INVALID : band_s2_r;        // [R1]
    rx_status = 9'h000;
    rx_status[BIT_BAND_HI:BIT_BAND_LO] = rx_band;            // [R1]
    rx_status[BIT_UNLOCK]              = rx_unlock;          // [R2]
    rx_status[3:0]                     = rx_flags_i;
  end

  // ************************************************************
  // readback select and shifter
  // ************************************************************
  logic [8:0] status_word;
  logic [8:0] out_sh_r, out_sh_nxt;
  logic       oe_r,     oe_nxt;
  logic [2:0] sel;

  assign sel   = rb_r[BIT_SEL_HI:BIT_SEL_LO];
  assign rb_go = frame_start && rb_r[BIT_READBACK_ENABLE]    // [R12]
                 && (rb_r[BIT_CONTINUOUS_READBACK] || shot_r); // [R11]

  always_comb begin
    status_word = 9'h000;
    if (sel == SEL_ERROR) begin                              // [R10]
      status_word = {1'b0, err_status_i};
    end else if (sel >= SEL_CHAN_FIRST && sel <= SEL_CHAN_LAST) begin
      status_word = {1'b0, chan_status_i[(sel - SEL_CHAN_FIRST) * 8 +: 8]};
    end else if (sel == SEL_RX_STATUS) begin
      status_word = rx_status;
    end
  end

  always_comb begin
    out_sh_nxt = out_sh_r;
    oe_nxt     = oe_r;
    if (rb_go) begin
      out_sh_nxt = status_word;
      oe_nxt     = 1'b1;
    end else if (!frame_active) begin
      oe_nxt = 1'b0;
    end else if (sclk_fall && oe_r) begin
      out_sh_nxt = {out_sh_r[7:0], 1'b0};
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_sh_r <= 9'h000;
      oe_r     <= 1'b0;
    end else begin
      out_sh_r <= out_sh_nxt;
      oe_r     <= oe_nxt;
    end
  end

  assign sdo_o    = out_sh_r[8];
  assign sdo_oe_o = oe_r;

  // ************************************************************
  // power control outputs
  // ************************************************************
  logic       save_r;
  logic       adc_off_r;
  logic [3:0] dac_off_r;
  logic [5:0] pd2_out_r;
  logic       adc_off_nxt;
  logic [3:0] dac_off_nxt;

  always_comb begin
    adc_off_nxt = pd1_r[BIT_ADC_POWER_OFF] | pd1_r[BIT_CHIP_POWER_SAVE]; // [R4] [R3]
    dac_off_nxt = pd1_r[BIT_DAC_HI:BIT_DAC_LO];              // [R4]
    if (pd1_r[BIT_ALL_DACS_OFF] || pd1_r[BIT_CHIP_POWER_SAVE]) begin
      dac_off_nxt = 4'hf;                                    // [R5] [R3]
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      save_r    <= RST_POWER_DOWN_ONE[BIT_CHIP_POWER_SAVE];
      adc_off_r <= RST_POWER_DOWN_ONE[BIT_ADC_POWER_OFF];
      dac_off_r <= RST_POWER_DOWN_ONE[BIT_DAC_HI:BIT_DAC_LO];
      pd2_out_r <= RST_POWER_DOWN_TWO[5:0];
    end else begin
      save_r    <= pd1_r[BIT_CHIP_POWER_SAVE];               // [R3]
      adc_off_r <= adc_off_nxt;
      dac_off_r <= dac_off_nxt;
      pd2_out_r <= pd2_r[5:0];                               // [R6] [R7] [R8] [R9]
    end
  end

  assign chip_power_save_o    = save_r;
  assign mute_o               = save_r;
  assign adc_power_off_o      = adc_off_r;
  assign dac_power_off_o      = dac_off_r;
  assign oscillator_off_o     = pd2_out_r[BIT_OSCILLATOR_OFF];
  assign first_pll_off_o      = pd2_out_r[BIT_FIRST_PLL_OFF];
  assign second_pll_off_o     = pd2_out_r[BIT_SECOND_PLL_OFF];
  assign clock_recovery_off_o = pd2_out_r[BIT_CLOCK_RECOVERY_OFF];
  assign transmitter_off_o    = pd2_out_r[BIT_TRANSMITTER_OFF];
  assign receiver_off_o       = pd2_out_r[BIT_RECEIVER_OFF];

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  band_unlocked_a: assert property (rx_unlock |-> rx_status[5:4] == 2'h0) // [R1]
    else $error("band not invalid while unlocked");
  unlock_flag_a: assert property (pd2_r[3] |-> rx_status[6]) // [R2]
    else $error("unlock clear with recovery off");
  power_save_a: assert property (pd1_r[0] |=> mute_o && adc_power_off_o && dac_power_off_o == 4'hf) // [R3]
    else $error("power save not applied");
  dac_each_a: assert property (!pd1_r[0] && !pd1_r[6] |=> dac_power_off_o == $past(pd1_r[5:2])) // [R4]
    else $error("dac off bits not followed");
  all_dacs_a: assert property (pd1_r[6] |=> dac_power_off_o == 4'hf) // [R5]
    else $error("all dacs off ignored");
  pll_follow_a: assert property (##1 first_pll_off_o == $past(pd2_r[1]) && oscillator_off_o == $past(pd2_r[0])) // [R6]
    else $error("pll or oscillator off mismatch");
  recovery_off_a: assert property (pd2_r[3] |=> clock_recovery_off_o) // [R7]
    else $error("recovery not powered down");
  tx_off_a: assert property (pd2_r[4] != transmitter_off_o |=> transmitter_off_o == $past(pd2_r[4])) // [R8]
    else $error("transmitter off mismatch");
  rx_off_a: assert property (!pd2_r[5] |=> !receiver_off_o) // [R9]
    else $error("receiver off mismatch");
  rx_select_a: assert property (rb_go && sel == 3'h6 |=> out_sh_r == $past(rx_status) && sdo_oe_o) // [R10]
    else $error("wrong status register loaded");
  cont_read_a: assert property (frame_start && rb_r[4] && rb_r[3] |=> sdo_oe_o) // [R11]
    else $error("continuous readback missed");
  no_read_a: assert property (frame_start && !rb_r[4] && !sdo_oe_o |=> !sdo_oe_o) // [R12]
    else $error("readback while disabled");
  soft_reset_a: assert property (soft_rst |=> pd1_r == 9'h07e && pd2_r == 9'h03e && rb_r == 9'h000) // [R13]
    else $error("software reset missed defaults");
  band_follow_a: assert property (!rx_unlock |-> rx_status[5:4] == band_s2_r) // [R1]
    else $error("band not reported while locked");
  adc_off_a: assert property (pd1_r[1] |=> adc_power_off_o) // [R4]
    else $error("adc not disabled");
  second_pll_a: assert property (##1 second_pll_off_o == $past(pd2_r[2])) // [R6]
    else $error("second pll off mismatch");
  recovery_on_a: assert property (!pd2_r[3] |=> !clock_recovery_off_o) // [R7]
    else $error("recovery held down");
  tx_on_a: assert property (!pd2_r[4] |=> !transmitter_off_o) // [R8]
    else $error("transmitter held off");
  rx_down_a: assert property (pd2_r[5] |=> receiver_off_o) // [R9]
    else $error("receiver not disabled");
  err_select_a: assert property (rb_go && sel == 3'h0 |=> // [R10]
    out_sh_r == {1'b0, $past(err_status_i)})
    else $error("error register not loaded");
  single_read_a: assert property (frame_start && !rb_r[3] && !shot_r && !sdo_oe_o |=> // [R11]
    !sdo_oe_o)
    else $error("single readback repeated");

endmodule

/* test/codec_power_readback_regs_test.sv */
// testbench: random and corner frames against a model of the registers
// assumes: host model drives the serial pins, bench drives status sources
`timescale 1ns/10ps

module codec_power_readback_regs_test
  import cprr_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  wire         sclk, sdin, latch_n, sdo, sdo_oe;
  logic [1:0]  rx_band = 2'h0;
  logic        rx_unlock = 1'b0;
  logic [3:0]  rx_flags = 4'h0;
  logic [7:0]  err_status = 8'h00;
  logic [39:0] chan_status = '0;
  logic        cps, mute, adc, osc, pll1, pll2, rec, tx, rx;
  logic [3:0]  dac;
  logic [12:0] pwr;
  logic [8:0]  pd1 = RST_POWER_DOWN_ONE;
  logic [8:0]  pd2 = RST_POWER_DOWN_TWO;
  logic [8:0]  rb = RST_READBACK_CONTROL;
  logic        arm = 1'b0;
  int          fails = 0;
  int          checks = 0;
  int          seed = 32'hd689;
  logic [8:0]  cor [6] = '{9'h000, 9'h1ff, 9'h014, 9'h040, 9'h001, 9'h002};

  assign pwr = {cps, mute, adc, dac, rx, tx, rec, pll2, pll1, osc};

  always #10 mclk = ~mclk;

  cprr_host host (.mclk_i(mclk), .sclk_o(sclk), .sdin_o(sdin), .latch_n_o(latch_n),
                  .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  cprr_top uut (.mclk_i(mclk), .nrst_i(nrst), .sclk_i(sclk), .sdin_i(sdin),
                .latch_n_i(latch_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
                .rx_band_i(rx_band), .rx_unlock_i(rx_unlock), .rx_flags_i(rx_flags),
                .err_status_i(err_status), .chan_status_i(chan_status),
                .chip_power_save_o(cps), .mute_o(mute), .adc_power_off_o(adc),
                .dac_power_off_o(dac), .oscillator_off_o(osc), .first_pll_off_o(pll1),
                .second_pll_off_o(pll2), .clock_recovery_off_o(rec),
                .transmitter_off_o(tx), .receiver_off_o(rx));

  // ************************************************************
  // expectations and compares
  // ************************************************************
  function automatic logic [12:0] exp_pwr(input logic [8:0] p1, input logic [8:0] p2);
    logic [3:0] d;
    d = (p1[6] | p1[0]) ? 4'hf : p1[5:2];
    return {p1[0], p1[0], p1[1] | p1[0], d, p2[5:0]};
  endfunction

  function automatic logic [8:0] exp_rd(input logic [8:0] r, input logic [8:0] p2);
    logic off;
    off = p2[3] | p2[5] | rx_unlock;
    case (r[2:0])
      SEL_ERROR:     return {1'b0, err_status};
      SEL_RX_STATUS: return {2'b00, off, off ? BAND_INVALID : rx_band, rx_flags};
      3'h7:          return 9'h000;
      default:       return {1'b0, chan_status[8*int'(r[2:0])-1 -: 8]};
    endcase
  endfunction

  task automatic chk_pwr(input logic [12:0] e, input logic [12:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR power outputs expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_rd(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one frame with random status sources and a random sclk pace
  task automatic frame(input logic [6:0] a, input logic [8:0] d, input int nb);
    logic [8:0] rd, erd;
    logic       oe, eoe;
    err_status  = 8'($random(seed));
    rx_flags    = 4'($random(seed));
    chan_status = {8'($random(seed)), 32'($random(seed))};
    host.tick(4);
    eoe = rb[4] & (rb[3] | arm);
    erd = exp_rd(rb, pd2);
    host.xfer({a, d}, nb, 6 + ($unsigned($random(seed)) % 4), rd, oe);
    chk_rd("readback drive", {8'h00, eoe}, {8'h00, oe});
    if (eoe) chk_rd("readback word", erd, rd);
    if (eoe) arm = 1'b0;
    if (nb == 16) begin
      if (a == OFS_POWER_DOWN_ONE) pd1 = d;
      if (a == OFS_POWER_DOWN_TWO) pd2 = d;
      if (a == OFS_READBACK_CONTROL) begin
        rb  = d;
        arm = 1'b1;
      end
      if (a == OFS_SOFTWARE_RESET) begin
        pd1 = RST_POWER_DOWN_ONE;
        pd2 = RST_POWER_DOWN_TWO;
        rb  = RST_READBACK_CONTROL;
        arm = 1'b0;
      end
    end
    host.tick(3);
    chk_pwr(exp_pwr(pd1, pd2), pwr);
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // watchdog and main sequence
  // ************************************************************
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge mclk);
    #1;
    nrst = 1'b1;
    host.tick(4);
    chk_pwr(exp_pwr(RST_POWER_DOWN_ONE, RST_POWER_DOWN_TWO), pwr);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      frame(OFS_POWER_DOWN_ONE, cor[i], 16);
      frame(OFS_POWER_DOWN_TWO, cor[i], 16);
    end
    for (int i = 0; i < 8; i++)
      frame(($random(seed) & 1) ? OFS_POWER_DOWN_TWO : OFS_POWER_DOWN_ONE, 9'($random(seed)), 16);
    $display("test power done");
    frame(OFS_POWER_DOWN_TWO, 9'h000, 16);
    for (int s = 0; s < 8; s++) begin
      frame(OFS_READBACK_CONTROL, 9'h010 | 9'(s), 16);
      frame(7'h7f, 9'h000, 16);
      frame(7'h7f, 9'h000, 16);
    end
    rx_unlock = 1'b0;
    rx_band   = BAND_48K;
    frame(OFS_POWER_DOWN_TWO, 9'h028, 16);
    frame(OFS_READBACK_CONTROL, 9'h016, 16);
    frame(7'h7f, 9'h000, 16);
    $display("test single readback done");
    frame(OFS_POWER_DOWN_TWO, 9'h000, 16);
    frame(OFS_READBACK_CONTROL, 9'h01e, 16);
    for (int b = 0; b < 8; b++) begin
      rx_band   = 2'(b);
      rx_unlock = b[2];
      frame(7'h7f, 9'($random(seed)), 16);
    end
    $display("test continuous readback done");
    frame(OFS_READBACK_CONTROL, 9'h00e, 16);
    frame(7'h7f, 9'h000, 16);
    frame(OFS_POWER_DOWN_ONE, 9'h1ff, 15);
    frame(OFS_POWER_DOWN_TWO, 9'h000, 15);
    $display("test refusals done");
    frame(OFS_POWER_DOWN_ONE, 9'h000, 16);
    frame(OFS_READBACK_CONTROL, 9'h01e, 16);
    frame(OFS_SOFTWARE_RESET, 9'($random(seed)), 16);
    frame(7'h7f, 9'h000, 16);
    $display("test software reset done");
    conclude();
  end
endmodule

/* test/cprr_host.sv */
// host model: drives the serial control pins, captures the readback word
// assumes: sclk idles low and stands still outside frames
`timescale 1ns/10ps

module cprr_host (
  // clock
  input  wire logic mclk_i,
  // serial pins
  output logic      sclk_o,
  output logic      sdin_o,
  output logic      latch_n_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  initial begin
    sclk_o    = 1'b0;
    sdin_o    = 1'b0;
    latch_n_o = 1'b1;
  end

  // ************************************************************
  // frame tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // nb bits msb first, each sclk phase ph mclk; sdo sampled before each of the first nine rises
  task automatic xfer(input logic [15:0] w, input int nb, input int ph,
                      output logic [8:0] rd, output logic oe);
    rd = 9'h000;
    oe = 1'b0;
    tick(1);
    latch_n_o = 1'b0;
    tick(ph);
    for (int i = 0; i < nb; i++) begin
      sdin_o = w[15-i];
      tick(ph);
      if (i < 9) begin
        rd[8-i] = sdo_oe_i ? sdo_i : ~sdo_i;
        oe      = oe | sdo_oe_i;
      end
      sclk_o = 1'b1;
      tick(ph);
      sclk_o = 1'b0;
    end
    tick(ph);
    latch_n_o = 1'b1;
    sdin_o    = ~sdin_o;
    tick(ph);
  endtask
endmodule
